/* File: src/tau_unit.v */
// Purpose: Sixteen-channel capture/compare timing array unit with two time bases.
// Assumes: All inputs synchronous to core_clk; configuration is plain ports.
// Notes on behaviour
// - Sixteen independent timing channels.
// - Resolution one clock, eight when staggered.
// - Two 16-bit timers with reload registers.
// - Timer clock: prescaled clock or auxiliary overflow.
// - Timers also count external count inputs.
// - Sixteen registers, own timer and function.
// - One pin per register, input or output.
// - Capture loads assigned timer on pin event.
// - Each capture raises its own request.
// - Capture edge rising, falling or both.
// - Compare registers match timer each count.
// - Mode zero: request only, repeated allowed.
// - Mode one: pin toggles each match.
// - Mode two: one request per period.
// - Mode three: set on match, clear overflow.
// - Paired registers each toggle their own pin on either match.
// - Single-event option stops a compare channel after one event; captures ignore it.
`timescale 1ns/1ps
`include "tau_defines.vh"
module tau_unit (
  // Clock, reset, enable
  input wire core_clk,
  input wire rst,
  input wire clk_en,
  // Time base control, two timers
  input wire [1:0] tmr_run,
  input wire stagger_en,
  input wire [3:0] tmr_clk_sel,
  input wire [7:0] tmr_prescale,
  input wire aux_gpt_timer_ovf,
  input wire [1:0] ext_count_in,
  input wire tmr_load_we,
  input wire tmr_load_sel,
  input wire [15:0] tmr_load_data,
  input wire reload_we,
  input wire reload_sel,
  input wire [15:0] reload_data,
  // Channel configuration
  input wire [47:0] ch_mode,
  input wire [31:0] ch_edge,
  input wire [15:0] ch_timer_sel,
  input wire [15:0] ch_single,
  input wire [15:0] ch_rearm,
  // Channel value write
  input wire val_we,
  input wire [3:0] val_idx,
  input wire [15:0] val_data,
  // Channel pins
  input wire [15:0] pin_in,
  output reg [15:0] pin_out,
  output reg [15:0] pin_oe,
  // Status
  output reg [15:0] ch_irq,
  output reg [31:0] timer_val,
  output wire [255:0] ch_val
);
  reg [15:0] tmr_r [0:1];
  reg [15:0] rld_r [0:1];
  reg [7:0] pre_cnt_r;
  reg [2:0] stg_cnt_r;
  reg [1:0] ext_d_r;
  reg [15:0] pin_d_r;
  reg [15:0] done_r;
  wire [15:0] cap_we;
  wire [255:0] cap_data;
  wire [15:0] pin_out_nxt;
  wire [15:0] pin_oe_nxt;
  wire [15:0] ch_irq_nxt;
  wire [15:0] done_nxt;
  wire [31:0] tmr_nxt;
  wire [31:0] rld_nxt;
  wire pre_tick;
  wire stg_tick;
  wire [1:0] step;
  wire [1:0] ovf;

  // Staggered operation only lets every eighth cycle act on the array.
  assign stg_tick = !stagger_en || (stg_cnt_r == `TAU_STAGGER_DIV);
  assign pre_tick = (pre_cnt_r == tmr_prescale);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pre_cnt_r <= 8'h00;
      stg_cnt_r <= 3'h0;
      ext_d_r <= 2'h0;
      pin_d_r <= 16'h0000;
    end else if (clk_en) begin
      pre_cnt_r <= pre_tick ? 8'h00 : pre_cnt_r + 8'h01;
      stg_cnt_r <= stg_cnt_r + 3'h1;
      // Edges are judged between acting slots, so a change between two staggered slots
      // is still seen at the next slot instead of being lost.
      if (stg_tick) begin
        ext_d_r <= ext_count_in;
        pin_d_r <= pin_in;
      end
    end
  end

  genvar t;
  generate
    for (t = 0; t < 2; t = t + 1) begin : tb
      reg src;
      always @* begin
        case (tmr_clk_sel[t*2 +: 2])
          `TAU_CLK_PRE0: src = 1'b1;
          `TAU_CLK_PRE1: src = pre_tick;
          `TAU_CLK_AUX: src = aux_gpt_timer_ovf;
          `TAU_CLK_EXT: src = ext_count_in[t] && !ext_d_r[t];
          default: src = 1'b0;
        endcase
      end
      assign step[t] = tmr_run[t] && src && stg_tick;
      assign ovf[t] = step[t] && (tmr_r[t] == 16'hFFFF);
      reg [15:0] tn;
      reg [15:0] rn;
      always @* begin
        rn = rld_r[t];
        if (reload_we && reload_sel == t) begin
          rn = reload_data;
        end
        tn = tmr_r[t];
        if (tmr_load_we && tmr_load_sel == t) begin
          tn = tmr_load_data;
        end else if (ovf[t]) begin
          tn = rld_r[t];
        end else if (step[t]) begin
          tn = tmr_r[t] + 16'h0001;
        end
      end
      assign tmr_nxt[t*16 +: 16] = tn;
      assign rld_nxt[t*16 +: 16] = rn;
    end
  endgenerate

  // One process owns each register, so no bit ever has two drivers.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tmr_r[0] <= `TAU_TIMER_RST;
      tmr_r[1] <= `TAU_TIMER_RST;
      rld_r[0] <= `TAU_RELOAD_RST;
      rld_r[1] <= `TAU_RELOAD_RST;
      timer_val <= {`TAU_TIMER_RST, `TAU_TIMER_RST};
    end else if (clk_en) begin
      tmr_r[0] <= tmr_nxt[15:0];
      tmr_r[1] <= tmr_nxt[31:16];
      rld_r[0] <= rld_nxt[15:0];
      rld_r[1] <= rld_nxt[31:16];
      timer_val <= {tmr_r[1], tmr_r[0]};
    end
  end

  tau_value_store u_store (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .sw_we(val_we),
    .sw_idx(val_idx),
    .sw_data(val_data),
    .cap_we(cap_we),
    .cap_data(cap_data),
    .rd_data(ch_val)
  );

  genvar c;
  generate
    for (c = 0; c < `TAU_NCH; c = c + 1) begin : ch
      wire [2:0] md = ch_mode[c*3 +: 3];
      wire ts = ch_timer_sel[c];
      wire [15:0] tv = ts ? tmr_r[1] : tmr_r[0];
      wire st = ts ? step[1] : step[0];
      wire ov = ts ? ovf[1] : ovf[0];
      wire rise = pin_in[c] && !pin_d_r[c];
      wire fall = !pin_in[c] && pin_d_r[c];
      wire [1:0] eg = ch_edge[c*2 +: 2];
      wire hit = ((eg == `TAU_E_RISE || eg == `TAU_E_BOTH) && rise) ||
                 ((eg == `TAU_E_FALL || eg == `TAU_E_BOTH) && fall);
      wire match = st && (ch_val[c*16 +: 16] == tv);
      // The partner of a paired channel is its neighbour in the same pair.
      wire [15:0] pv = ch_val[(c ^ 1)*16 +: 16];
      wire pmatch = (ch_mode[(c ^ 1)*3 +: 3] == `TAU_M_DBL) && st && (pv == tv);
      wire blocked = done_r[c];
      reg po_n;
      reg irq_n;
      reg done_n;
      assign cap_we[c] = (md == `TAU_M_CAP) && hit && stg_tick;
      assign cap_data[c*16 +: 16] = tv;
      assign pin_oe_nxt[c] = (md != `TAU_M_OFF) && (md != `TAU_M_CAP) &&
                             (md != `TAU_M_CMP0) && (md != `TAU_M_CMP2);
      always @* begin
        po_n = pin_out[c];
        irq_n = 1'b0;
        done_n = done_r[c];
        if (ch_rearm[c]) begin
          done_n = 1'b0;
        end
        // Periodic modes free the once-per-period lock on overflow; single-event never.
        if (ov && !ch_single[c] && (md == `TAU_M_CMP2 || md == `TAU_M_CMP3)) begin
          done_n = 1'b0;
        end
        // A match in the same cycle as a rearm still sees the old lock, so a locked channel loses that event.
        case (md)
          `TAU_M_CAP: begin
            if (cap_we[c]) begin
              irq_n = 1'b1;
            end
          end
          `TAU_M_CMP0: begin
            if (match && !blocked) begin
              irq_n = 1'b1;
              done_n = ch_single[c];
            end
          end
          `TAU_M_CMP1: begin
            if (match && !blocked) begin
              po_n = !pin_out[c];
              irq_n = 1'b1;
              done_n = ch_single[c];
            end
          end
          `TAU_M_CMP2: begin
            if (match && !blocked) begin
              irq_n = 1'b1;
              done_n = 1'b1;
            end
          end
          `TAU_M_CMP3: begin
            if (ov) begin
              po_n = 1'b0;
            end else if (match && !blocked) begin
              po_n = 1'b1;
              irq_n = 1'b1;
              done_n = 1'b1;
            end
          end
          `TAU_M_DBL: begin
            if ((match || pmatch) && !blocked) begin
              po_n = !pin_out[c];
              irq_n = match;
              done_n = ch_single[c];
            end
          end
          default: begin
            po_n = pin_out[c];
          end
        endcase
      end
      assign pin_out_nxt[c] = po_n;
      assign ch_irq_nxt[c] = irq_n;
      assign done_nxt[c] = done_n;
    end
  endgenerate

  // All channel pin and request outputs leave from one set of flip-flops; ch_val comes from the value store.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_out <= 16'h0000;
      pin_oe <= 16'h0000;
      ch_irq <= 16'h0000;
      done_r <= 16'h0000;
    end else if (clk_en) begin
      pin_out <= pin_out_nxt;
      pin_oe <= pin_oe_nxt;
      ch_irq <= ch_irq_nxt;
      done_r <= done_nxt;
    end
  end
endmodule

/* File: src/tau_defines.vh */
// Purpose: Constants for the sixteen-channel timing array unit.
// Assumes: Included by the design files by bare name.
// Notes: Definitions only.
`ifndef TAU_DEFINES_VH
`define TAU_DEFINES_VH
`define TAU_NCH 16
`define TAU_TW 16
`define TAU_TIMER_RST 16'h0000
`define TAU_RELOAD_RST 16'h0000
`define TAU_STAGGER_DIV 3'h7
`define TAU_CLK_PRE0 2'h0
`define TAU_CLK_PRE1 2'h1
`define TAU_CLK_AUX 2'h2
`define TAU_CLK_EXT 2'h3
`define TAU_M_OFF 3'h0
`define TAU_M_CAP 3'h1
`define TAU_M_CMP0 3'h2
`define TAU_M_CMP1 3'h3
`define TAU_M_CMP2 3'h4
`define TAU_M_CMP3 3'h5
`define TAU_M_DBL 3'h6
`define TAU_E_RISE 2'h1
`define TAU_E_FALL 2'h2
`define TAU_E_BOTH 2'h3
`endif

/* File: src/tau_value_store.v */
// Purpose: Holds the sixteen capture/compare values with registered read data.
// Assumes: Synchronous write ports per entry, one clock.
// Notes: Capture loads take priority over software writes to the same entry.
`timescale 1ns/1ps
`include "tau_defines.vh"
module tau_value_store (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  input wire clk_en,
  // Software write
  input wire sw_we,
  input wire [3:0] sw_idx,
  input wire [15:0] sw_data,
  // Capture load per entry
  input wire [15:0] cap_we,
  input wire [255:0] cap_data,
  // Read data
  output reg [255:0] rd_data
);
  wire [255:0] rd_nxt;
  genvar g;
  generate
    for (g = 0; g < `TAU_NCH; g = g + 1) begin : ent
      assign rd_nxt[g*16 +: 16] = cap_we[g] ? cap_data[g*16 +: 16] :
                                  (sw_we && sw_idx == g) ? sw_data : rd_data[g*16 +: 16];
    end
  endgenerate
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data <= 256'h0;
    end else if (clk_en) begin
      rd_data <= rd_nxt;
    end
  end
endmodule

/* File: tb/tau_chk.sv */
// Purpose: Port checker for the timing array unit.
// Assumes: Bound to tau_unit; one clock domain.
// Notes: Channels 0 and 4 stand for the compare and capture kinds.
`timescale 1ns/1ps
`include "tau_defines.vh"
module tau_chk (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Inputs
  input wire clk_en,
  input wire [1:0] tmr_run,
  input wire stagger_en,
  input wire [3:0] tmr_clk_sel,
  input wire tmr_load_we,
  input wire reload_we,
  input wire reload_sel,
  input wire [15:0] reload_data,
  input wire [47:0] ch_mode,
  input wire [15:0] pin_in,
  // Outputs
  input wire [15:0] pin_out,
  input wire [15:0] pin_oe,
  input wire [15:0] ch_irq,
  input wire [31:0] timer_val
);
  reg [15:0] rl0_r;
  wire run0 = clk_en && tmr_run[0] && tmr_clk_sel[1:0] == 2'h0 && !tmr_load_we;
  wire [2:0] m0 = ch_mode[2:0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  always @(posedge core_clk or posedge rst)
    if (rst) rl0_r <= 16'h0;
    else if (clk_en && reload_we && !reload_sel) rl0_r <= reload_data;
  a_reset_quiet: assert property ($fell(rst) |-> pin_out == 16'h0 && pin_oe == 16'h0 &&
    ch_irq == 16'h0 && timer_val == 32'h0) else $error("outputs not clear after reset");
  a_oe_by_mode: assert property (clk_en && $stable(m0) |=> pin_oe[0] ==
    ($past(m0) == 3'h3 || $past(m0) == 3'h5 || $past(m0) == 3'h6))
    else $error("pin enable wrong");
  a_cap_on_edge: assert property (ch_irq[4] && ch_mode[14:12] == `TAU_M_CAP &&
    !$past(stagger_en) |-> $past(pin_in[4]) != $past(pin_in[4], 2)) else $error("capture no edge");
  a_freeze_hold: assert property (!clk_en |=> $stable(pin_out) && $stable(timer_val))
    else $error("state moved while disabled");
  a_count_step: assert property ((run0 && !stagger_en)[*3] ##0 timer_val[15:0] != 16'hFFFF
    |=> timer_val[15:0] == $past(timer_val[15:0]) + 16'h1) else $error("timer step wrong");
  a_wrap_reload: assert property ((run0 && !stagger_en)[*3] ##0 timer_val[15:0] == 16'hFFFF
    |=> timer_val[15:0] == rl0_r) else $error("no reload on wrap");
  a_stagger_slow: assert property ((run0 && stagger_en)[*3] ##0 $changed(timer_val[15:0])
    |=> $stable(timer_val[15:0])) else $error("staggered timer too fast");
  a_toggle_irq: assert property (clk_en && m0 == `TAU_M_CMP1 && $stable(m0)
    |=> $changed(pin_out[0]) == ch_irq[0]) else $error("toggle and request differ");
  c_capture: cover property (ch_irq[4]);
  c_toggle: cover property (ch_irq[0] && pin_out[0]);
  c_clear: cover property ($fell(pin_out[3]));
endmodule
bind tau_unit tau_chk u_chk (.*);

/* File: tb/tau_pin_model.sv */
// Purpose: Channel pin wiring and outside signal sources.
// Assumes: pin_oe high while the unit drives a pin.
// Notes: An undriven pin follows the level the bench asks for.
`timescale 1ns/1ps
module tau_pin_model (
  // Unit side
  input wire [15:0] pin_out,
  input wire [15:0] pin_oe,
  // Bench side
  input wire [15:0] ext_lvl,
  output wire [15:0] pin_in
);
  // A driven pin reads back its own level, as a real pad does.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

/* File: tb/test_tau_unit.sv */
// Purpose: Self-checking bench for the timing array unit.
// Assumes: Checker is bound; pin model closes the pins.
// Notes: Timers stop during captures so captured values are exact.
`timescale 1ns/1ps
`include "tau_defines.vh"
module test_tau_unit;
  logic core_clk = 0, rst = 1, clk_en = 0, stagger_en = 0, aux_gpt_timer_ovf = 0, hit;
  logic tmr_load_we = 0, tmr_load_sel = 0, reload_we = 0, reload_sel = 0, val_we = 0;
  logic [1:0] tmr_run = 0, ext_count_in = 0;
  logic [3:0] tmr_clk_sel = 0, val_idx = 0;
  logic [7:0] tmr_prescale = 0;
  logic [15:0] tmr_load_data = 0, reload_data = 0, val_data = 0, ch_timer_sel = 0, tv;
  logic [15:0] ch_single = 0, ch_rearm = 0, ext_lvl = 0, pin_in, pin_out, pin_oe, ch_irq;
  logic [47:0] ch_mode = 0;
  logic [31:0] ch_edge = 0, timer_val;
  logic [255:0] ch_val;
  int n_fail = 0, comparisons = 0;
  tau_unit dut (.*);
  tau_pin_model u_pins (.*);
  initial forever #2 core_clk = ~core_clk;
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input int k, input logic [3:0] i, input logic [15:0] d);
    @(posedge core_clk);
    {tmr_load_we, reload_we, val_we} <= {k == 0, k == 1, k == 2};
    {tmr_load_sel, reload_sel, val_idx} <= {i[0], i[0], i};
    {tmr_load_data, reload_data, val_data} <= {3{d}};
    @(posedge core_clk);
    {tmr_load_we, reload_we, val_we} <= 3'h0;
  endtask
  // Waits a bounded time for a request; settled values are read 1 ns past the edge.
  task automatic wirq(input int c, input int n);
    hit = 0;
    repeat (n) if (!hit) begin
      @(posedge core_clk);
      #1;
      hit = ch_irq[c] === 1'h1;
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    end_of_test;
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    #1;
    chk("oe", 16'h0, pin_oe);
    chk("tmr0", 16'h0, timer_val[15:0]);
    @(posedge core_clk);
    {clk_en, tmr_run, tmr_clk_sel, tmr_prescale} <= {1'h1, 2'h0, 4'h4, 8'h3};
    ch_mode <= {18'h0, `TAU_M_DBL, `TAU_M_DBL, `TAU_M_OFF, `TAU_M_CAP, `TAU_M_CAP,
      `TAU_M_CAP, `TAU_M_CMP3, `TAU_M_CMP2, `TAU_M_CMP0, `TAU_M_CMP1};
    ch_edge[13:8] <= {`TAU_E_BOTH, `TAU_E_FALL, `TAU_E_RISE};
    ch_timer_sel[5] <= 1'h1;
    wr(2, 0, 16'h5); wr(2, 1, 16'h5); wr(2, 8, 16'h5); wr(2, 9, 16'h14);
    wr(2, 2, 16'h1E); wr(2, 3, 16'h0106); wr(1, 0, 16'h0100); wr(0, 0, 16'h0);
    @(posedge core_clk);
    tmr_run <= 2'h1;
    wirq(0, 20);
    chk("irq", 16'h0103, ch_irq);
    chk("pin", 16'h0301, pin_out & 16'h0301);
    wr(2, 0, 16'h14); wr(2, 1, 16'h14);
    wirq(0, 20);
    chk("irq", 16'h0203, ch_irq);
    chk("pin", 16'h0, pin_out & 16'h0301);
    wirq(2, 20);
    chk("irq2", 16'h1, hit);
    wr(2, 2, 16'h28);
    wirq(2, 30);
    chk("irq2", 16'h0, hit);
    @(posedge core_clk);
    clk_en <= 0;
    repeat (3) @(posedge core_clk);
    #1;
    tv = timer_val[15:0];
    repeat (4) @(posedge core_clk);
    #1;
    chk("freeze", tv, timer_val[15:0]);
    @(posedge core_clk);
    clk_en <= 1;
    wr(2, 2, 16'h0104); wr(0, 0, 16'hFFFE);
    wirq(2, 20);
    chk("irq2", 16'h1, hit);
    wirq(3, 20);
    chk("pin3", 16'h8, pin_out & 16'h8);
    chk("wrap", 16'h1, timer_val[15:8] == 8'h01);
    wr(0, 0, 16'hFFFE);
    repeat (4) @(posedge core_clk);
    #1;
    chk("pin3", 16'h0, pin_out & 16'h8);
    @(posedge core_clk);
    stagger_en <= 1;
    #1;
    tv = timer_val[15:0];
    repeat (40) @(posedge core_clk);
    #1;
    chk("stag", 16'h1, (timer_val[15:0] - tv) inside {[4:6]});
    @(posedge core_clk);
    {stagger_en, tmr_run} <= 3'h0;
    wr(0, 0, 16'h1234); wr(0, 1, 16'hABCD);
    @(posedge core_clk);
    ext_lvl <= 16'h0070;
    wirq(4, 10);
    chk("irq", 16'h0050, ch_irq & 16'h0070);
    chk("cap4", 16'h1234, ch_val[79:64]);
    chk("cap6", 16'h1234, ch_val[111:96]);
    chk("oe", 16'h0309, pin_oe);
    @(posedge core_clk);
    ext_lvl <= 16'h0;
    wirq(5, 10);
    chk("irq", 16'h0060, ch_irq & 16'h0070);
    chk("cap5", 16'hABCD, ch_val[95:80]);
    @(posedge core_clk);
    {tmr_run, tmr_clk_sel} <= {2'h1, 4'h7};
    repeat (3) begin
      @(posedge core_clk);
      ext_count_in <= 2'h1;
      @(posedge core_clk);
      ext_count_in <= 2'h0;
    end
    repeat (3) @(posedge core_clk);
    #1;
    chk("ext", 16'h1237, timer_val[15:0]);
    @(posedge core_clk);
    {tmr_clk_sel, ch_single[1]} <= {4'h4, 1'h1};
    wr(0, 0, 16'h0010);
    wirq(1, 20);
    chk("single", 16'h1, hit);
    wr(0, 0, 16'h0010);
    wirq(1, 20);
    chk("single", 16'h0, hit);
    @(posedge core_clk);
    ch_rearm[1] <= 1'h1;
    @(posedge core_clk);
    ch_rearm[1] <= 1'h0;
    wr(0, 0, 16'h0010);
    wirq(1, 20);
    chk("rearm", 16'h1, hit);
    @(posedge core_clk);
    tmr_run <= 2'h2;
    #1;
    tv = timer_val[31:16];
    repeat (40) @(posedge core_clk);
    #1;
    chk("pre", 16'h1, (timer_val[31:16] - tv) inside {[9:11]});
    end_of_test;
  end
endmodule
